// file: core/hcr_regs.sv
`timescale 1ns/100ps
// hub configuration register bank with reset interconnect and pullup control
`include "hcr_cfg.svh"

// Notes on behaviour
// [RULE1] config-2 cleared only by power-up reset
// [RULE2] bit0 enables port 5, reset disabled
// [RULE3] bit1 marks port 5 permanent, reset removable
// [RULE4] bits5:4 encode embedded port-6 state
// [RULE5] bit7 reports power switching, reset zero
// [RULE6] power-good delay byte, 2 ms units
// [RULE7] power-good delay cleared only by power-up
// [RULE8] product id low/high bytes, reset zero
// [RULE9] vendor id low/high bytes, reset zero
// [RULE10] internal reset from power-up or gated function
// [RULE11] gate bit controls function reset, starts off
// [RULE12] internal reset clears only the product and vendor id regs
// [RULE13] reset output true or inverted by polarity
// [RULE14] external controller resets from reset output
// [RULE15] connect bit one drives pullup high
// [RULE16] connect bit zero drives pullup low
// [RULE17] connect is usb control bit7, reset zero
// [RULE18] reserved config-2 bits read zero
module hcr_regs
  import hcr_pkg::*;
#(
  parameter int ADDR_W = 4 // word index width
) (
  // clock and power-up reset
  input wire logic clk_i,
  input wire logic rst_i,
  // function reset source
  input wire logic usb_function_reset_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W+1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // hub config fields
  output logic port5_enable_o,
  output logic port5_permanent_o,
  output hcr_p6_state_t port6_embedded_state_o,
  output logic power_switch_present_o,
  output logic [7:0] hub_power_good_delay_o,
  output logic [15:0] hub_product_id_o,
  output logic [15:0] hub_vendor_id_o,
  // reset and pullup pins
  output logic internal_reset_o,
  output logic reset_output_pin_o,
  output logic pullup_drive_pin_o
);

  // elaboration check: the map needs nine word slots, so four index bits at least
  if (ADDR_W < 4) begin : g_addr_check
    $error("hcr_regs: ADDR_W must be at least 4");
  end

  // register storage
  logic [7:0] hub_config_second_q; // port5/port6/power switch
  logic [7:0] hub_power_good_delay_q; // descriptor offset 5
  logic [7:0] hub_product_id_low_q;
  logic [7:0] hub_product_id_high_q;
  logic [7:0] hub_vendor_id_low_q;
  logic [7:0] hub_vendor_id_high_q;
  logic [7:0] usb_control_reg_q; // connect and function reset gate
  logic [7:0] global_control_reg_q; // reset output polarity
  logic ack_q;
  logic err_q;
  logic [31:0] dat_q;

  // bus decode
  logic req;
  logic wr_ok;
  logic [ADDR_W-1:0] idx;
  logic mapped;
  logic int_rst;

  // word index from byte address; low two bits ignored
  assign idx = wb_adr_i[ADDR_W+1:2];
  // a new request is one not yet answered, so ack lasts one cycle
  assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;

  // decode: true for any implemented word index
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a <= ADDR_W'(`HCR_OFF_STATUS);
  endfunction

  // byte write with mask; reserved positions stay zero
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] mask);
    return (old & ~mask) | (nw & mask);
  endfunction

  assign mapped = is_mapped(idx);
  // lane 0 carries the byte registers
  assign wr_ok = req & wb_we_i & mapped & wb_sel_i[0];

  // reset interconnect lives in its own module
  hcr_reset_ctl u_rst (
    .power_up_reset_signal_i(rst_i),
    .usb_function_reset_i(usb_function_reset_i),
    .function_reset_gate_i(usb_control_reg_q[`HCR_BIT_FUNCTION_RESET_GATE]),
    .rst_polarity_i(global_control_reg_q[`HCR_BIT_RST_POL]),
    .internal_reset_o(int_rst),
    .reset_output_pin_o(reset_output_pin_o)
  );
  assign internal_reset_o = int_rst;

  // control regs: cleared by power-up reset only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      usb_control_reg_q <= `HCR_RST_BYTE; // [RULE11] [RULE17]
      global_control_reg_q <= `HCR_RST_BYTE;
    end else if (wr_ok) begin
      if (idx == ADDR_W'(`HCR_OFF_USB_CTL)) begin
        usb_control_reg_q <= wr_byte(usb_control_reg_q, wb_dat_i[7:0], `HCR_USB_CTL_WMASK);
      end
      if (idx == ADDR_W'(`HCR_OFF_GLOB_CTL)) begin
        global_control_reg_q <= wr_byte(global_control_reg_q, wb_dat_i[7:0],
                                        `HCR_GLOB_CTL_WMASK);
      end
    end
  end

  // config-2 and power-good delay survive function reset by design
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hub_config_second_q <= `HCR_RST_BYTE; // [RULE1] [RULE2] [RULE3] [RULE5]
      hub_power_good_delay_q <= `HCR_RST_BYTE; // [RULE7]
    end else if (wr_ok) begin
      if (idx == ADDR_W'(`HCR_OFF_HUB_CFG2)) begin
        hub_config_second_q <= wr_byte(hub_config_second_q, wb_dat_i[7:0],
                                       `HCR_CFG2_WMASK); // [RULE18]
      end
      if (idx == ADDR_W'(`HCR_OFF_POTG)) begin
        hub_power_good_delay_q <= wb_dat_i[7:0]; // [RULE6]
      end
    end
  end

  // id bytes follow the internal reset, so a gated function reset clears them
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      hub_product_id_low_q <= `HCR_RST_BYTE; // [RULE8] [RULE12]
      hub_product_id_high_q <= `HCR_RST_BYTE;
      hub_vendor_id_low_q <= `HCR_RST_BYTE; // [RULE9]
      hub_vendor_id_high_q <= `HCR_RST_BYTE;
    end else if (wr_ok) begin
      if (idx == ADDR_W'(`HCR_OFF_PID_LO)) begin
        hub_product_id_low_q <= wb_dat_i[7:0];
      end
      if (idx == ADDR_W'(`HCR_OFF_PID_HI)) begin
        hub_product_id_high_q <= wb_dat_i[7:0];
      end
      if (idx == ADDR_W'(`HCR_OFF_VID_LO)) begin
        hub_vendor_id_low_q <= wb_dat_i[7:0];
      end
      if (idx == ADDR_W'(`HCR_OFF_VID_HI)) begin
        hub_vendor_id_high_q <= wb_dat_i[7:0];
      end
    end
  end

  // bus answer: ack for mapped, err for unmapped, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ack_q <= req & mapped;
      err_q <= req & ~mapped;
    end
  end

  // read data registered alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~wb_we_i) begin
      case (idx)
        ADDR_W'(`HCR_OFF_HUB_CFG2): dat_q <= {24'h00_0000, hub_config_second_q};
        ADDR_W'(`HCR_OFF_POTG): dat_q <= {24'h00_0000, hub_power_good_delay_q};
        ADDR_W'(`HCR_OFF_PID_LO): dat_q <= {24'h00_0000, hub_product_id_low_q};
        ADDR_W'(`HCR_OFF_PID_HI): dat_q <= {24'h00_0000, hub_product_id_high_q};
        ADDR_W'(`HCR_OFF_VID_LO): dat_q <= {24'h00_0000, hub_vendor_id_low_q};
        ADDR_W'(`HCR_OFF_VID_HI): dat_q <= {24'h00_0000, hub_vendor_id_high_q};
        ADDR_W'(`HCR_OFF_USB_CTL): dat_q <= {24'h00_0000, usb_control_reg_q};
        ADDR_W'(`HCR_OFF_GLOB_CTL): dat_q <= {24'h00_0000, global_control_reg_q};
        // status: live internal reset and pullup state
        ADDR_W'(`HCR_OFF_STATUS): dat_q <= {30'h0000_0000, pullup_drive_pin_o, int_rst};
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = dat_q;

  // field outputs straight from the register bits
  assign port5_enable_o = hub_config_second_q[`HCR_BIT_P5E]; // [RULE2]
  assign port5_permanent_o = hub_config_second_q[`HCR_BIT_P5A]; // [RULE3]
  assign port6_embedded_state_o =
    hcr_p6_state_t'(hub_config_second_q[`HCR_BIT_P6_HI:`HCR_BIT_P6_LO]); // [RULE4]
  assign power_switch_present_o = hub_config_second_q[`HCR_BIT_POWER_SWITCH_PRESENT]; // [RULE5]
  assign hub_power_good_delay_o = hub_power_good_delay_q; // [RULE6]
  assign hub_product_id_o = {hub_product_id_high_q, hub_product_id_low_q}; // [RULE8]
  assign hub_vendor_id_o = {hub_vendor_id_high_q, hub_vendor_id_low_q}; // [RULE9]

  // pullup is a push-pull drive: high connects, low disconnects
  assign pullup_drive_pin_o = usb_control_reg_q[`HCR_BIT_UPSTREAM_CONNECT]; // [RULE15] [RULE16]
endmodule

// file: include/hcr_cfg.svh
// register offsets, field positions and reset values for the hub config block
`ifndef HCR_CFG_SVH
`define HCR_CFG_SVH
`define HCR_OFF_HUB_CFG2 4'h0
`define HCR_OFF_POTG 4'h1
`define HCR_OFF_PID_LO 4'h2
`define HCR_OFF_PID_HI 4'h3
`define HCR_OFF_VID_LO 4'h4
`define HCR_OFF_VID_HI 4'h5
`define HCR_OFF_USB_CTL 4'h6
`define HCR_OFF_GLOB_CTL 4'h7
`define HCR_OFF_STATUS 4'h8
`define HCR_BIT_P5E 0
`define HCR_BIT_P5A 1
`define HCR_BIT_P6_LO 4
`define HCR_BIT_P6_HI 5
`define HCR_BIT_POWER_SWITCH_PRESENT 7
`define HCR_CFG2_WMASK 8'hB3
`define HCR_BIT_FUNCTION_RESET_GATE 4
`define HCR_BIT_UPSTREAM_CONNECT 7
`define HCR_USB_CTL_WMASK 8'h90
`define HCR_BIT_RST_POL 0
`define HCR_GLOB_CTL_WMASK 8'h01
`define HCR_RST_BYTE 8'h00
`define HCR_POTG_UNIT_MS 2
`endif

// file: include/hcr_pkg.sv
// types shared by the hub config register block
package hcr_pkg;
  typedef enum logic [1:0] {
    HCR_P6_ABSENT = 2'b00,
    HCR_P6_PERMANENT = 2'b01,
    HCR_P6_REMOVABLE_DETACHED = 2'b10,
    HCR_P6_REMOVABLE_ATTACHED = 2'b11
  } hcr_p6_state_t;
endpackage

// file: core/hcr_reset_ctl.sv
`timescale 1ns/100ps
// reset interconnect: combines power-up and gated function reset
module hcr_reset_ctl (
  // resets in
  input wire logic power_up_reset_signal_i,
  input wire logic usb_function_reset_i,
  // control
  input wire logic function_reset_gate_i,
  input wire logic rst_polarity_i,
  // resets out
  output logic internal_reset_o,
  output logic reset_output_pin_o
);
  // internal reset: power-up, or function reset only when gated in
  always_comb begin
    internal_reset_o = power_up_reset_signal_i |
      (usb_function_reset_i & function_reset_gate_i); // [RULE10] [RULE11]
    // polarity mux for the external reset pin
    reset_output_pin_o = rst_polarity_i ? ~internal_reset_o : internal_reset_o; // [RULE13]
  end
endmodule

// file: dv/hcr_regs_properties.sv
`timescale 1ns/100ps
// port-level checker for the hub config register block
module hcr_regs_checker
  import hcr_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  // clock, resets, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic usb_function_reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W+1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // fields and pins
  input wire logic port5_enable_o,
  input wire logic port5_permanent_o,
  input wire hcr_p6_state_t port6_embedded_state_o,
  input wire logic power_switch_present_o,
  input wire logic [7:0] hub_power_good_delay_o,
  input wire logic [15:0] hub_product_id_o,
  input wire logic [15:0] hub_vendor_id_o,
  input wire logic internal_reset_o,
  input wire logic reset_output_pin_o,
  input wire logic pullup_drive_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a fresh request, any write, a config-2 read answer
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire wr = wb_cyc_i && wb_stb_i && wb_we_i;
  wire cfg_rd = wb_ack_o && !wb_we_i && wb_adr_i[ADDR_W+1:2] == 4'h0;
  AST_ANSWER: assert property (req |=> wb_ack_o != wb_err_o)
    else $error("request not answered once in the next cycle");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_CFG_READ: assert property (cfg_rd |-> wb_dat_o == {24'h0, power_switch_present_o,
    1'b0, port6_embedded_state_o, 2'b00, port5_permanent_o, port5_enable_o})
    else $error("config-2 read differs from its fields");
  // a power-up reset clears fields at its last edge, so it is kept out of the antecedent
  AST_CFG_HOLD: assert property (!wr && !rst_i |=> $stable({port5_enable_o, port5_permanent_o,
    port6_embedded_state_o, power_switch_present_o, hub_power_good_delay_o}))
    else $error("config field moved without a write");
  AST_PIN_HOLD: assert property (!wr && !rst_i |=> $stable(pullup_drive_pin_o) &&
    $stable(reset_output_pin_o ^ internal_reset_o))
    else $error("pullup or reset polarity moved without a write");
  AST_ID_CLEAR: assert property (internal_reset_o |=> !hub_product_id_o && !hub_vendor_id_o)
    else $error("id bytes kept through internal reset");
  AST_PWRUP: assert property ($fell(rst_i) |-> !pullup_drive_pin_o && !internal_reset_o
    && !hub_power_good_delay_o)
    else $error("state after power-up reset not cleared");
  AST_RST_IN: assert property (disable iff (1'b0) rst_i |-> internal_reset_o)
    else $error("power-up reset not on internal reset");
  AST_FR_OFF: assert property (!usb_function_reset_i |-> !internal_reset_o)
    else $error("internal reset without a source");
  // main scenarios reached
  cover property (cfg_rd);
  cover property (usb_function_reset_i && internal_reset_o);
  cover property (wb_err_o);
endmodule

bind hcr_regs hcr_regs_checker #(.ADDR_W(ADDR_W)) i_chk (.clk_i, .rst_i, .usb_function_reset_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port5_enable_o,
  .port5_permanent_o, .port6_embedded_state_o, .power_switch_present_o, .hub_power_good_delay_o,
  .hub_product_id_o, .hub_vendor_id_o, .internal_reset_o, .reset_output_pin_o,
  .pullup_drive_pin_o);

// file: dv/hcr_host_model.sv
`timescale 1ns/100ps
// upstream hub port and external controller as seen at the pins
module hcr_host_model (
  // pins from the block
  input wire logic pullup_drive_pin_i,
  input wire logic mcu_reset_i,
  // what the far side sees
  output logic attached_o,
  output logic mcu_held_o
);
  // push-pull pin, so the host sees exactly the driven level
  assign attached_o = pullup_drive_pin_i;
  // the controller takes its reset straight from the reset output
  assign mcu_held_o = mcu_reset_i;
endmodule

// file: dv/hcr_regs_tb.sv
`timescale 1ns/100ps
// self-checking bench for the hub config register block
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module hcr_regs_tb;
  import hcr_pkg::*;
  logic clk_i = 0, rst_i = 1, usb_function_reset_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, port5_enable_o, port5_permanent_o, power_switch_present_o, e;
  logic internal_reset_o, reset_output_pin_o, pullup_drive_pin_o, att, held;
  hcr_p6_state_t port6_embedded_state_o;
  logic [7:0] hub_power_good_delay_o;
  logic [15:0] hub_product_id_o, hub_vendor_id_o;
  // model registers and their writable masks, status is read-only
  int errors = 0, tests_run = 0, m[9];
  int wm[9] = '{8'hb3, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h90, 8'h01, 0};
  hcr_regs i_dut (.clk_i, .rst_i, .usb_function_reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .port5_enable_o,
    .port5_permanent_o, .port6_embedded_state_o, .power_switch_present_o, .hub_power_good_delay_o,
    .hub_product_id_o, .hub_vendor_id_o, .internal_reset_o, .reset_output_pin_o,
    .pullup_drive_pin_o);
  hcr_host_model i_host (.pullup_drive_pin_i(pullup_drive_pin_o),
    .mcu_reset_i(reset_output_pin_o), .attached_o(att), .mcu_held_o(held));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic wrap_up();
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one classic cycle, held until ack or err is sampled, bounded wait
  task automatic xfer(input int a, input logic w, input int d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_adr_i <= 6'(a * 4);
    wb_sel_i <= 4'h1;
    wb_dat_i <= 32'(d & 8'hff);
    // look at the answer mid-cycle, where it is settled, and release at the next edge
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    rd = wb_dat_o;
    e = wb_err_o;
    @(posedge clk_i);
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    if (n >= 20) begin
      errors++;
      wrap_up();
    end
  endtask
  // compare every field output and the pullup and reset output pins with the model
  task automatic outs();
    `CHK("cfg", m[0], {power_switch_present_o, 1'b0, port6_embedded_state_o, 2'b0, port5_permanent_o, port5_enable_o})
    `CHK("potg", m[1], hub_power_good_delay_o)
    `CHK("pid", m[3] * 256 + m[2], hub_product_id_o)
    `CHK("vid", m[5] * 256 + m[4], hub_vendor_id_o)
    `CHK("pur", m[6] >> 7, pullup_drive_pin_o)
    `CHK("att", m[6] >> 7, att)
    `CHK("reset_output_pin", m[7] ^ internal_reset_o, held)
  endtask
  task automatic wr(input int a, input int d);
    xfer(a, 1, d);
    `CHK("werr", a > 8, e)
    if (a < 8) m[a] = d & wm[a];
    @(negedge clk_i);
    outs();
  endtask
  task automatic rchk(input int a);
    xfer(a, 0, 0);
    `CHK("rerr", a > 8, e)
    if (a < 9) `CHK("rd", a == 8 ? m[6] >> 6 & 2 : m[a], rd)
  endtask
  // one-cycle function reset; only the id bytes fall when gated
  task automatic frst();
    @(posedge clk_i);
    usb_function_reset_i <= 1;
    @(negedge clk_i);
    `CHK("irst", m[6] >> 4 & 1, internal_reset_o)
    @(posedge clk_i);
    usb_function_reset_i <= 0;
    if (m[6] & 8'h10) for (int i = 2; i < 6; i++) m[i] = 0;
    @(negedge clk_i);
    outs();
  endtask
  initial begin
    void'($urandom(14479));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    for (int a = 0; a < 10; a++) rchk(a);
    for (int c = 0; c < 4; c++) wr(0, c << 4 | 8'h4d);
    repeat (40) begin
      wr($urandom_range(9), $urandom);
      rchk($urandom_range(9));
    end
    wr(6, 8'h80);
    frst();
    wr(6, 8'h90);
    wr(7, 1);
    frst();
    for (int a = 0; a < 9; a++) rchk(a);
    @(posedge clk_i);
    rst_i <= 1;
    @(negedge clk_i);
    `CHK("prst", 1, internal_reset_o)
    m = '{default: 0};
    @(posedge clk_i);
    rst_i <= 0;
    @(negedge clk_i);
    outs();
    wrap_up();
  end
endmodule
